// >>> rtl/etc_pkg.sv
// constants, register map and field layout for the eight-bit timer with compare
package etc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_CMP    = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ    = 8'h10;
  localparam logic [7:0] ADDR_ACTIVE = 8'h14;
  // control register fields
  localparam int CS_LSB   = 0;
  localparam int WGM_LSB  = 3;
  localparam int COM_LSB  = 5;
  localparam int FOC_BIT  = 7;
  // flag register fields
  localparam int OVF_BIT  = 0;
  localparam int CMF_BIT  = 1;
  // interrupt control fields
  localparam int CIE_BIT  = 0;
  localparam int GIE_BIT  = 1;
  localparam int OIE_BIT  = 2;
  localparam int OSRV_BIT = 3;
  localparam int CSRV_BIT = 4;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  // prescaler taps
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] DIV8    = 10'h007;
  localparam logic [PRE_W-1:0] DIV64   = 10'h03F;
  localparam logic [PRE_W-1:0] DIV256  = 10'h0FF;
  localparam logic [PRE_W-1:0] DIV1024 = 10'h3FF;
  localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
  typedef enum logic [2:0] {
    CS_STOP, CS_SYS, CS_D8, CS_D64, CS_D256, CS_D1024, CS_EXT_FALL, CS_EXT_RISE
  } etc_clksel_t;
  typedef enum logic [1:0] {WG_NORMAL, WG_PWM_PC, WG_CTC, WG_PWM_FAST} etc_wgm_t;
  typedef enum logic [1:0] {COM_OFF, COM_TOGGLE, COM_CLEAR, COM_SET} etc_com_t;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : etc_pkg

// >>> rtl/etc_timer.sv
// eight-bit timer/counter with one compare channel and an AXI4-Lite slave
// What this block does
// RQ1: counter at zero raises the bottom indication
// RQ2: counter at 255 raises the max indication to the waveform logic
// RQ3: top is 255 or the compare value, chosen by mode
// RQ4: three-bit clock_select picks tick source; zero stops the counter
// RQ5: software reads and writes counter_value at any time
// RQ6: software counter write beats a coincident clear or count
// RQ7: each tick clears, increments or decrements the counter as mode directs
// RQ8: two waveform_mode_select bits set the count sequence
// RQ9: overflow_flag sets where mode says and may request an interrupt
// RQ10: counter compared continuously with active compare value, match on equal
// RQ11: compare_match_flag sets on the tick after the matching tick
// RQ12: compare interrupt needs enable, global enable and flag all set
// RQ13: flag cleared by service or writing one; writing zero does nothing
// RQ14: match, max and bottom drive the waveform logic with mode and action; the code uses only match and max there, not bottom
// RQ15: compare value double-buffered in PWM modes only
// RQ16: buffered value moves to active register only at top or bottom
// RQ17: software reaches the buffer when buffering, else the active register
// RQ18: force strobe in non-PWM modes acts on output like a real match
// RQ19: forced compare sets no flag and leaves the counter alone
// RQ20: counter write blocks a match on the next tick, even stopped
// RQ21: selection 1 is system clock; others divide by 8, 64, 256, 1024
// RQ22: external source ticks on rising edge for 7, falling for 6
// RQ23: reset clears counter, compare, control and flags; state moves on ticks
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module etc_timer
  import etc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ext_clk_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             compare_output_pin_out,
  output logic             compare_irq_out,
  output logic             overflow_irq_out
);
  function automatic logic is_pwm(input logic [1:0] m);
    is_pwm = (m == WG_PWM_PC) || (m == WG_PWM_FAST);
  endfunction : is_pwm

  logic       rst_s1_q, rst_s2_q;
  logic       ext_s1_q, ext_s2_q, ext_s3_q;
  logic [PRE_W-1:0] pre_q;
  logic [7:0] count_q, count_d, ocr_q, ocr_buf_q;
  logic [2:0] cs_q;
  logic [1:0] wgm_q, com_q;
  logic       down_q, ovf_q, cmf_q, oc_q, blk_q;
  logic       cie_q, gie_q, oie_q;
  logic       aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // reset released through two flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_b = rst_s2_q;

  // external pin: two sync flops, edge detector looks only at the second and third
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      pre_q    <= '0;
    end else begin
      ext_s1_q <= ext_clk_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      pre_q    <= pre_q + PRE_ONE;
    end
  end

  // tick selection
  wire ext_rise = ext_s2_q & ~ext_s3_q;
  wire ext_fall = ~ext_s2_q & ext_s3_q;
  logic tick;
  always_comb begin
    case (etc_clksel_t'(cs_q))
      CS_STOP:     tick = 1'b0;                          // [RQ4]
      CS_SYS:      tick = 1'b1;                          // [RQ21]
      CS_D8:       tick = (pre_q[2:0] == DIV8[2:0]);     // [RQ21]
      CS_D64:      tick = (pre_q[5:0] == DIV64[5:0]);
      CS_D256:     tick = (pre_q[7:0] == DIV256[7:0]);
      CS_D1024:    tick = (pre_q == DIV1024);
      CS_EXT_FALL: tick = ext_fall;                      // [RQ22]
      CS_EXT_RISE: tick = ext_rise;                      // [RQ22]
      default:     tick = 1'b0;
    endcase
  end

  // bus: a write completes once both address and data are held
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  wire        wr_go   = aw_hold_q & w_hold_q;
  wire        wr_lane = wr_go & w_strb_q[0];
  wire [7:0]  wr_byte = w_data_q[7:0];
  wire wr_ctrl  = wr_lane && (aw_addr_q == ADDR_CTRL);
  wire wr_count = wr_lane && (aw_addr_q == ADDR_COUNT);
  wire wr_cmp   = wr_lane && (aw_addr_q == ADDR_CMP);
  wire wr_flags = wr_lane && (aw_addr_q == ADDR_FLAGS);
  wire wr_irq   = wr_lane && (aw_addr_q == ADDR_IRQ);
  wire wr_known = (aw_addr_q == ADDR_CTRL) || (aw_addr_q == ADDR_COUNT) ||
                  (aw_addr_q == ADDR_CMP) || (aw_addr_q == ADDR_FLAGS) ||
                  (aw_addr_q == ADDR_IRQ) || (aw_addr_q == ADDR_ACTIVE);

  // counter indications
  wire pwm      = is_pwm(wgm_q);                           // [RQ15]
  wire at_bot   = (count_q == CNT_BOTTOM);                 // [RQ1]
  wire at_max   = (count_q == CNT_MAX);                    // [RQ2]
  wire [7:0] top_val = (wgm_q == WG_CTC) ? ocr_q : CNT_MAX; // [RQ3]
  wire at_top   = (count_q == top_val);
  wire match    = (count_q == ocr_q);                      // [RQ10]
  wire match_ok = match & ~blk_q;                          // [RQ20]

  // next count from mode: normal wraps, ctc clears at top, fast clears at max,
  // phase-correct turns round at max and bottom
  logic down_d;
  always_comb begin
    count_d = count_q + 8'h01;
    down_d  = down_q;
    case (etc_wgm_t'(wgm_q))                               // [RQ8]
      WG_CTC:      count_d = at_top ? CNT_BOTTOM : count_q + 8'h01;  // [RQ7]
      WG_PWM_FAST: count_d = at_max ? CNT_BOTTOM : count_q + 8'h01;
      WG_PWM_PC: begin
        if (down_q && at_bot) begin
          down_d  = 1'b0;
          count_d = count_q + 8'h01;
        end else if (!down_q && at_max) begin
          down_d  = 1'b1;
          count_d = count_q - 8'h01;
        end else begin
          count_d = down_q ? count_q - 8'h01 : count_q + 8'h01;
        end
      end
      default:     count_d = count_q + 8'h01;
    endcase
  end

  // overflow point per mode
  logic ovf_evt;
  always_comb begin
    case (etc_wgm_t'(wgm_q))
      WG_PWM_PC: ovf_evt = tick & at_bot & down_q;         // [RQ9]
      WG_CTC:    ovf_evt = tick & at_max;
      default:   ovf_evt = tick & at_max;
    endcase
  end

  // buffer update point: top for fast pwm, top-turn for phase correct
  wire buf_load = pwm && tick &&
                  ((wgm_q == WG_PWM_FAST) ? at_max : (at_max & ~down_q)); // [RQ16]

  // action and mode written along with the strobe apply to it at once
  wire [1:0] com_now = wr_ctrl ? wr_byte[COM_LSB +: 2] : com_q;
  wire       pwm_now = wr_ctrl ? is_pwm(wr_byte[WGM_LSB +: 2]) : pwm;
  // force strobe: only outside pwm, acts on the output alone
  wire force_cmp = wr_ctrl & wr_byte[FOC_BIT] & ~pwm_now;  // [RQ18] [RQ19]
  wire oc_evt    = force_cmp | (tick & match_ok & ~pwm);   // [RQ14]

  // pwm output: fast with clear action sets at max, clears on match (set action the reverse); phase correct by direction
  logic oc_d;
  always_comb begin
    oc_d = oc_q;
    if (oc_evt) begin
      case (etc_com_t'(com_now))
        COM_TOGGLE: oc_d = ~oc_q;
        COM_CLEAR:  oc_d = 1'b0;
        COM_SET:    oc_d = 1'b1;
        default:    oc_d = oc_q;
      endcase
    end else if (pwm && tick && com_now[1]) begin
      if (wgm_q == WG_PWM_FAST) begin
        if (match_ok) oc_d = com_now[0];
        else if (at_max) oc_d = ~com_now[0];
      end else if (match_ok) begin
        oc_d = down_q ^ com_now[0] ? 1'b1 : 1'b0;
      end
    end
  end

  wire cmf_clr = (wr_flags & wr_byte[CMF_BIT]) | (wr_irq & wr_byte[CSRV_BIT]); // [RQ13]
  wire ovf_clr = (wr_flags & wr_byte[OVF_BIT]) | (wr_irq & wr_byte[OSRV_BIT]);
  wire cmf_set = tick & match_ok;                          // [RQ11]

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin                                      // [RQ23]
      count_q      <= RST_BYTE;
      ocr_q        <= RST_BYTE;
      ocr_buf_q    <= RST_BYTE;
      cs_q         <= 3'h0;
      wgm_q        <= 2'h0;
      com_q        <= 2'h0;
      down_q       <= 1'b0;
      ovf_q        <= 1'b0;
      cmf_q        <= 1'b0;
      oc_q         <= 1'b0;
      blk_q        <= 1'b0;
      cie_q        <= 1'b0;
      gie_q        <= 1'b0;
      oie_q        <= 1'b0;
    end else begin
      if (wr_count) begin
        count_q <= wr_byte;                                // [RQ5] [RQ6]
      end else if (tick) begin
        count_q <= count_d;                                // [RQ7] [RQ23]
        down_q  <= down_d;
      end
      // block stays until a tick consumes it
      if (wr_count) blk_q <= 1'b1;                         // [RQ20]
      else if (tick) blk_q <= 1'b0;
      if (wr_ctrl) begin
        cs_q  <= wr_byte[CS_LSB +: 3];
        wgm_q <= wr_byte[WGM_LSB +: 2];
        com_q <= wr_byte[COM_LSB +: 2];
      end
      if (wr_cmp && !pwm) ocr_q <= wr_byte;                // [RQ17]
      else if (buf_load) ocr_q <= ocr_buf_q;               // [RQ16]
      if (wr_cmp) ocr_buf_q <= wr_byte;
      if (wr_irq) begin
        cie_q <= wr_byte[CIE_BIT];
        gie_q <= wr_byte[GIE_BIT];
        oie_q <= wr_byte[OIE_BIT];
      end
      // set beats clear
      cmf_q <= cmf_set | (cmf_q & ~cmf_clr);               // [RQ11] [RQ13]
      ovf_q <= ovf_evt | (ovf_q & ~ovf_clr);               // [RQ9]
      oc_q  <= oc_d;
    end
  end

  assign compare_irq_out        = cie_q & gie_q & cmf_q;   // [RQ12]
  assign overflow_irq_out       = oie_q & gie_q & ovf_q;   // [RQ9]
  assign compare_output_pin_out = oc_q;

  // write channel holds and response
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read: buffer visible while buffering, ADDR_ACTIVE shows direction, output and the match, max and bottom indications
  wire [7:0] cmp_view = pwm ? ocr_buf_q : ocr_q;           // [RQ17]
  logic [7:0] rd_byte;
  logic       rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL:   rd_byte = {1'b0, com_q, wgm_q, cs_q};
      ADDR_COUNT:  rd_byte = count_q;                      // [RQ5]
      ADDR_CMP:    rd_byte = cmp_view;
      ADDR_FLAGS:  rd_byte = {6'h00, cmf_q, ovf_q};
      ADDR_IRQ:    rd_byte = {5'h00, oie_q, gie_q, cie_q};
      ADDR_ACTIVE: rd_byte = {down_q, oc_q, 3'h0, at_max, at_bot, match};
      default: begin
        rd_byte  = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_flag_after_match: assert property (@(posedge clk_in) disable iff (!rst_b)
    tick && match_ok |=> cmf_q)                            // [RQ11]
    else $error("compare flag not set after match tick");
  a_irq_gating: assert property (@(posedge clk_in) disable iff (!rst_b)
    cie_q && gie_q && cmf_set && !wr_irq |=> compare_irq_out) // [RQ12]
    else $error("enabled compare flag gave no irq");
  a_stop_holds: assert property (@(posedge clk_in) disable iff (!rst_b)
    (cs_q == 3'h0) && !wr_count |=> $stable(count_q))      // [RQ4]
    else $error("counter moved while stopped");
  a_write_wins: assert property (@(posedge clk_in) disable iff (!rst_b)
    wr_count |=> count_q == $past(wr_byte))                // [RQ6]
    else $error("counter write lost");
  a_block_match: assert property (@(posedge clk_in) disable iff (!rst_b)
    wr_count ##1 (tick && !wr_count) |-> !cmf_set)         // [RQ20]
    else $error("match not blocked after counter write");
  a_buf_hold: assert property (@(posedge clk_in) disable iff (!rst_b)
    pwm && !buf_load && $past(pwm) |=> $stable(ocr_q))     // [RQ16]
    else $error("active compare changed off top");
  a_force_noflag: assert property (@(posedge clk_in) disable iff (!rst_b)
    force_cmp && !cmf_q && !cmf_set |=> !cmf_q)            // [RQ19]
    else $error("forced compare set the flag");
  a_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_b)
    wr_flags && wr_byte[CMF_BIT] && !cmf_set |=> !cmf_q)   // [RQ13]
    else $error("write one did not clear flag");
  c_overflow: cover property (@(posedge clk_in) disable iff (!rst_b) ovf_evt);
  c_match_flag: cover property (@(posedge clk_in) disable iff (!rst_b) cmf_set);
  c_buf_load: cover property (@(posedge clk_in) disable iff (!rst_b) buf_load);
  c_force: cover property (@(posedge clk_in) disable iff (!rst_b) force_cmp);
endmodule : etc_timer
`default_nettype wire

// >>> verification/eight_bit_timer_compare_tb.sv
// self-checking bench for the eight-bit timer with compare channel
`timescale 1ns/1ps
`default_nettype none
module eight_bit_timer_compare_tb;
  import etc_pkg::*;
  logic        clk_in        = 1'h0;
  logic        rst_b_in      = 1'h0;
  logic        ext_clk_in    = 1'h0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'h0;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid  = 1'h0;
  logic        s_axi_bready  = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready  = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  logic        pin_w, cirq_w, oirq_w;
  int          err_total  = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  etc_timer i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ext_clk_in(ext_clk_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .compare_output_pin_out(pin_w), .compare_irq_out(cirq_w), .overflow_irq_out(oirq_w)
  );

  always #25 clk_in = ~clk_in;

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // whole run needs about 3000 cycles; generous ceiling
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ready is sampled at the falling edge, where it already holds its edge value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_hit, w_hit, aw_ok, w_ok, b_hit;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk_in);
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit = s_axi_wvalid & s_axi_wready;
      @(posedge clk_in);
      if (aw_hit === 1'h1) begin
        s_axi_awvalid <= 1'h0;
        aw_ok = 1'h1;
      end
      if (w_hit === 1'h1) begin
        s_axi_wvalid <= 1'h0;
        w_ok = 1'h1;
      end
    end
    do begin
      @(negedge clk_in);
      b_hit = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk_in);
    end while (b_hit !== 1'h1);
    s_axi_bready <= 1'h0;
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic hit;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(negedge clk_in);
      hit = s_axi_arready;
      @(posedge clk_in);
    end while (hit !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge clk_in);
      hit = s_axi_rvalid;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk_in);
    end while (hit !== 1'h1);
    s_axi_rready <= 1'h0;
    @(posedge clk_in);
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    rd(a);
    chk(rdat & m, e);
  endtask : rchk

  // six cycles covers the synchroniser and edge detector delay
  task automatic ext_set(input logic v);
    ext_clk_in <= v;
    repeat (6) @(posedge clk_in);
  endtask : ext_set

  task automatic pulse(input int n);
    repeat (n) begin
      ext_set(1'h1);
      ext_set(1'h0);
    end
  endtask : pulse

  // prescaler free-runs, so the first tick lands anywhere in a period: check a band only
  task automatic presc(input logic [7:0] sel, input int waits);
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_COUNT, 8'hFF);
    wr(ADDR_CTRL, sel);
    repeat (waits) @(posedge clk_in);
    wr(ADDR_CTRL, 8'h00);
    rchk(ADDR_COUNT, 32'h0, 32'hFC);
    rchk(ADDR_FLAGS, 32'h01, 32'h01);
  endtask : presc

  initial begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    rchk(ADDR_CTRL, 32'h0);
    rchk(ADDR_COUNT, 32'h0);
    rchk(ADDR_CMP, 32'h0);
    rchk(ADDR_FLAGS, 32'h0);
    rchk(ADDR_ACTIVE, 32'h03, 32'h87);
    rd(8'h18);
    chk(32'(rsp), 32'(RESP_SLVERR));
    chk(rdat, 32'h0);
    wr(8'h1C, 8'h55);
    chk(32'(rsp), 32'(RESP_SLVERR));
    $display("test reset done");
    wr(ADDR_COUNT, 8'h5A);
    chk(32'(rsp), 32'(RESP_OKAY));
    pulse(2);
    rchk(ADDR_COUNT, 32'h5A);
    wr(ADDR_COUNT, 8'hFF);
    rchk(ADDR_ACTIVE, 32'h04, 32'h07);
    $display("test stopped done");
    wr(ADDR_CMP, 8'h05);
    wr(ADDR_COUNT, 8'h03);
    wr(ADDR_CTRL, 8'h07);
    pulse(2);
    rchk(ADDR_COUNT, 32'h05);
    rchk(ADDR_FLAGS, 32'h0);
    pulse(1);
    rchk(ADDR_FLAGS, 32'h02);
    wr(ADDR_FLAGS, 8'h00);
    rchk(ADDR_FLAGS, 32'h02);
    wr(ADDR_FLAGS, 8'h02);
    rchk(ADDR_FLAGS, 32'h0);
    wr(ADDR_COUNT, 8'h05);
    pulse(1);
    rchk(ADDR_COUNT, 32'h06);
    rchk(ADDR_FLAGS, 32'h0);
    wr(ADDR_CTRL, 8'h06);
    ext_set(1'h1);
    rchk(ADDR_COUNT, 32'h06);
    ext_set(1'h0);
    rchk(ADDR_COUNT, 32'h07);
    $display("test compare done");
    wr(ADDR_CTRL, 8'h07);
    wr(ADDR_COUNT, 8'hFE);
    pulse(2);
    rchk(ADDR_FLAGS, 32'h01);
    wr(ADDR_IRQ, 8'h04);
    chk(32'(oirq_w), 32'h0);
    wr(ADDR_IRQ, 8'h06);
    chk(32'(oirq_w), 32'h1);
    wr(ADDR_IRQ, 8'h0E);
    chk(32'(oirq_w), 32'h0);
    rchk(ADDR_FLAGS, 32'h0);
    wr(ADDR_COUNT, 8'h04);
    pulse(2);
    wr(ADDR_IRQ, 8'h01);
    chk(32'(cirq_w), 32'h0);
    wr(ADDR_IRQ, 8'h03);
    chk(32'(cirq_w), 32'h1);
    wr(ADDR_IRQ, 8'h13);
    chk(32'(cirq_w), 32'h0);
    rchk(ADDR_FLAGS, 32'h0);
    wr(ADDR_IRQ, 8'h00);
    $display("test interrupt done");
    wr(ADDR_CTRL, 8'h17);
    wr(ADDR_CMP, 8'h03);
    wr(ADDR_COUNT, 8'h00);
    pulse(3);
    rchk(ADDR_COUNT, 32'h03);
    pulse(1);
    rchk(ADDR_COUNT, 32'h00);
    wr(ADDR_CTRL, 8'h1F);
    wr(ADDR_CMP, 8'h00);
    rchk(ADDR_CMP, 32'h00);
    wr(ADDR_COUNT, 8'h02);
    pulse(1);
    rchk(ADDR_ACTIVE, 32'h01, 32'h01);
    wr(ADDR_COUNT, 8'hFE);
    pulse(2);
    rchk(ADDR_ACTIVE, 32'h03, 32'h03);
    wr(ADDR_CTRL, 8'h0F);
    wr(ADDR_COUNT, 8'hFE);
    pulse(2);
    rchk(ADDR_COUNT, 32'hFE);
    $display("test modes done");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_CTRL, 8'hE0);
    chk(32'(pin_w), 32'h1);
    wr(ADDR_CTRL, 8'hC0);
    chk(32'(pin_w), 32'h0);
    wr(ADDR_CTRL, 8'hA0);
    chk(32'(pin_w), 32'h1);
    rchk(ADDR_CTRL, 32'h20);
    rchk(ADDR_FLAGS, 32'h0);
    rchk(ADDR_COUNT, 32'hFE);
    wr(ADDR_CTRL, 8'hD8);
    chk(32'(pin_w), 32'h1);
    $display("test force done");
    presc(8'h01, 0);
    presc(8'h02, 16);
    presc(8'h03, 100);
    presc(8'h04, 400);
    presc(8'h05, 1500);
    $display("test prescaler done");
    close_out();
  end
endmodule : eight_bit_timer_compare_tb
`default_nettype wire
